// >>> rtl/gnpcp_params.svh
// constants of the gateway node parameter command parser
`ifndef GNPCP_PARAMS_SVH
`define GNPCP_PARAMS_SVH
// ========================================================
// register map (byte addresses)
`define GNPCP_OFS_REQ 8'h00
`define GNPCP_OFS_CTRL 8'h04
`define GNPCP_OFS_STAT 8'h08
`define GNPCP_OFS_RSP 8'h0C
// ========================================================
// command codes
`define GNPCP_CMD_GET_PERM 8'h01
`define GNPCP_CMD_WR_PARAM 8'h02
`define GNPCP_CMD_RD_PARAM 8'h03
`define GNPCP_CMD_STORE_PRM 8'h04
`define GNPCP_CMD_STORE_CFG 8'h07
`define GNPCP_CMD_OFFLINE 8'h0A
// ========================================================
// error codes, 7 bits in response byte 1
`define GNPCP_ERR_OK 7'h00
`define GNPCP_ERR_UNKNOWN 7'h01
`define GNPCP_ERR_INACTIVE 7'h02
`define GNPCP_ERR_OFFLINE 7'h03
`define GNPCP_ERR_NOT_CFG 7'h04
// ========================================================
// request and response field positions
`define GNPCP_REQ_CODE 7:0
`define GNPCP_REQ_SEG 8
`define GNPCP_REQ_TOG 15
`define GNPCP_REQ_OFFL 16
`define GNPCP_REQ_ADDR 20:16
`define GNPCP_REQ_AB 21
`define GNPCP_REQ_PARAM 27:24
`define GNPCP_RSP_CODE 7:0
`define GNPCP_RSP_ERR 14:8
`define GNPCP_RSP_TOG 15
`define GNPCP_RSP_PAY 23:16
`define GNPCP_RSP_NIB 19:16
// control and status bit positions
`define GNPCP_CTRL_START 0
`define GNPCP_STAT_CLR 0
// ========================================================
// sizes and reset values
`define GNPCP_NODES 128
`define GNPCP_PARAM_RST 4'hF
`define GNPCP_IDX_LAST 7'h7F
`endif

// >>> rtl/gnpcp_pkg.sv
// types of the gateway node parameter command parser
package gnpcp_pkg;
  // ========================================================
  // sequencer states
  typedef enum logic [1:0] {
    GNPCP_ST_BOOT = 2'b00,
    GNPCP_ST_BOOT_WAIT = 2'b01,
    GNPCP_ST_IDLE = 2'b10,
    GNPCP_ST_WP_WAIT = 2'b11
  } gnpcp_state_t;
  // ========================================================
  // whole module state
  typedef struct packed {
    gnpcp_state_t st;
    logic [127:0][3:0] stored;
    logic [127:0][3:0] image;
    logic [31:0] req;
    logic [23:0] rsp;
    logic done;
    logic offline;
    logic nreq;
    logic [6:0] nidx;
    logic [3:0] ndata;
    logic [6:0] idx;
    logic cfg_store;
  } gnpcp_regs_t;
endpackage : gnpcp_pkg

// >>> rtl/gnpcp_top.sv
// command interpreter of the gateway acyclic command channel
// What this block does
// - code 0x01 returns stored expected parameter, one byte payloads
// - stored parameter sits in bits 3..0 of response byte 2
// - code 0x02 replaces node current parameter with request byte 3 bits 3..0
// - written parameter kept only in volatile storage
// - write parameter only acts on active nodes
// - write parameter response byte 2 is the node echo
// - write parameter: two byte request payload, one byte response payload
// - code 0x03 returns the node current parameter value
// - read value is last parameter sent, else stored one, bits 3..0
// - code 0x04 copies all current parameters into stored set
// - at every start stored parameters are sent to the active nodes
// - store commands carry no payload beyond code and header
// - code 0x07 saves current node configuration as expected configuration
// - store configuration executes only in configuration mode
// - code 0x0A switches between online and offline
// - request byte 2 bit 0: 1 offline, 0 online
// - offline: no traffic with nodes, user requests still served
// - offline state not retained; comes up online after reset
`timescale 1ns/1ps
`default_nettype none
`include "gnpcp_params.svh"

module gnpcp_top
  import gnpcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // node side, same clock domain
  input wire logic [127:0] node_active_in,
  input wire logic cfg_mode_in,
  input wire logic node_resp_valid_in,
  input wire logic [3:0] node_resp_data_in,
  output logic node_wr_req_out,
  output logic [6:0] node_wr_idx_out,
  output logic [3:0] node_wr_data_out,
  output logic cfg_store_out,
  // status
  output logic offline_out,
  output logic busy_out
);

  // ========================================================
  // state
  gnpcp_regs_t s_r;
  gnpcp_regs_t s_nxt;

  logic apb_wr;
  logic apb_acc;
  logic go;
  logic [7:0] code;
  logic tog;
  logic [6:0] ridx;
  logic [3:0] img_sel;
  logic [3:0] sto_sel;
  logic mapped;
  logic seg_bit;
  logic ab_bit;
  logic [4:0] naddr;
  logic [3:0] wparam;
  logic offl_req;

  // apb decode, zero wait states
  assign apb_acc = psel_in & penable_in;
  assign apb_wr = apb_acc & pwrite_in;
  assign mapped = (paddr_in == `GNPCP_OFS_REQ) || (paddr_in == `GNPCP_OFS_CTRL)
               || (paddr_in == `GNPCP_OFS_STAT) || (paddr_in == `GNPCP_OFS_RSP);
  assign pready_out = 1'b1;
  assign pslverr_out = apb_acc & ~mapped;
  // start accepted only while idle; a start during boot or a node wait is dropped
  assign go = apb_wr & (paddr_in == `GNPCP_OFS_CTRL) & pwdata_in[`GNPCP_CTRL_START]
            & (s_r.st == GNPCP_ST_IDLE);

  assign code = s_r.req[`GNPCP_REQ_CODE];
  assign tog = s_r.req[`GNPCP_REQ_TOG];
  // node index is segment, then A/B, then the five address bits
  assign seg_bit = s_r.req[`GNPCP_REQ_SEG];
  assign ab_bit = s_r.req[`GNPCP_REQ_AB];
  assign naddr = s_r.req[`GNPCP_REQ_ADDR];
  assign ridx = {seg_bit, ab_bit, naddr};
  // byte 3 nibble for a write, byte 2 bit 0 for the offline flag
  assign wparam = s_r.req[`GNPCP_REQ_PARAM];
  assign offl_req = s_r.req[`GNPCP_REQ_OFFL];
  assign img_sel = s_r.image[ridx];
  assign sto_sel = s_r.stored[ridx];

  // read mux over registered state
  always_comb begin
    prdata_out = 32'h00000000;
    case (paddr_in)
      `GNPCP_OFS_REQ: prdata_out = s_r.req;
      `GNPCP_OFS_STAT: prdata_out = {29'h00000000, s_r.offline,
                                     (s_r.st != GNPCP_ST_IDLE), s_r.done};
      `GNPCP_OFS_RSP: prdata_out = {8'h00, s_r.rsp};
      default: prdata_out = 32'h00000000;
    endcase
  end

  // ========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.nreq = 1'b0;
    s_nxt.cfg_store = 1'b0;
    // request held steady while a command runs
    if (apb_wr && paddr_in == `GNPCP_OFS_REQ && s_r.st == GNPCP_ST_IDLE) begin
      s_nxt.req = pwdata_in;
    end
    // done cleared by writing one; a completion below overrides it
    if (apb_wr && paddr_in == `GNPCP_OFS_STAT && pwdata_in[`GNPCP_STAT_CLR]) begin
      s_nxt.done = 1'b0;
    end
    case (s_r.st)
      // boot walk sends stored parameters to active nodes
      GNPCP_ST_BOOT: begin
        if (node_active_in[s_r.idx]) begin
          s_nxt.nreq = 1'b1;
          s_nxt.nidx = s_r.idx;
          s_nxt.ndata = s_r.stored[s_r.idx];
          s_nxt.image[s_r.idx] = s_r.stored[s_r.idx];
          s_nxt.st = GNPCP_ST_BOOT_WAIT;
        end else if (s_r.idx == `GNPCP_IDX_LAST) begin
          s_nxt.st = GNPCP_ST_IDLE;
        end else begin
          s_nxt.idx = s_r.idx + 7'h01;
        end
      end
      GNPCP_ST_BOOT_WAIT: begin
        if (node_resp_valid_in) begin
          if (s_r.idx == `GNPCP_IDX_LAST) begin
            s_nxt.st = GNPCP_ST_IDLE;
          end else begin
            s_nxt.idx = s_r.idx + 7'h01;
            s_nxt.st = GNPCP_ST_BOOT;
          end
        end
      end
      GNPCP_ST_IDLE: begin
        if (go) begin
          s_nxt.done = 1'b1;
          // echo code and toggle, error defaults to ok
          s_nxt.rsp = {8'h00, tog, `GNPCP_ERR_OK, code};
          case (code)
            `GNPCP_CMD_GET_PERM: s_nxt.rsp[`GNPCP_RSP_PAY] = {4'h0, sto_sel};
            `GNPCP_CMD_RD_PARAM: s_nxt.rsp[`GNPCP_RSP_PAY] = {4'h0, img_sel};
            `GNPCP_CMD_WR_PARAM: begin
              if (s_r.offline) begin
                s_nxt.rsp[`GNPCP_RSP_ERR] = `GNPCP_ERR_OFFLINE;
              end else if (!node_active_in[ridx]) begin
                s_nxt.rsp[`GNPCP_RSP_ERR] = `GNPCP_ERR_INACTIVE;
              end else begin
                // volatile image takes byte 3 nibble
                s_nxt.image[ridx] = wparam;
                s_nxt.nreq = 1'b1;
                s_nxt.nidx = ridx;
                s_nxt.ndata = wparam;
                s_nxt.done = 1'b0;
                s_nxt.st = GNPCP_ST_WP_WAIT;
              end
            end
            // copy all images into stored set
            `GNPCP_CMD_STORE_PRM: s_nxt.stored = s_r.image;
            `GNPCP_CMD_STORE_CFG: begin
              if (cfg_mode_in) begin
                // pulse tells the config store to latch
                s_nxt.cfg_store = 1'b1;
              end else begin
                s_nxt.rsp[`GNPCP_RSP_ERR] = `GNPCP_ERR_NOT_CFG;
              end
            end
            // byte 2 bit 0 selects offline
            `GNPCP_CMD_OFFLINE: s_nxt.offline = offl_req;
            default: s_nxt.rsp[`GNPCP_RSP_ERR] = `GNPCP_ERR_UNKNOWN;
          endcase
        end
      end
      GNPCP_ST_WP_WAIT: begin
        if (node_resp_valid_in) begin
          s_nxt.rsp[`GNPCP_RSP_PAY] = {4'h0, node_resp_data_in};
          s_nxt.done = 1'b1;
          s_nxt.st = GNPCP_ST_IDLE;
        end
      end
      default: s_nxt.st = GNPCP_ST_IDLE;
    endcase
  end

  // ========================================================
  // state register
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r.st <= GNPCP_ST_BOOT;
      s_r.stored <= {`GNPCP_NODES{`GNPCP_PARAM_RST}};
      s_r.image <= {`GNPCP_NODES{`GNPCP_PARAM_RST}};
      s_r.req <= 32'h00000000;
      s_r.rsp <= 24'h000000;
      s_r.done <= 1'b0;
      s_r.offline <= 1'b0;
      s_r.nreq <= 1'b0;
      s_r.nidx <= 7'h00;
      s_r.ndata <= 4'h0;
      s_r.idx <= 7'h00;
      s_r.cfg_store <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs from flip-flops, busy_out decoded from the state register
  assign node_wr_req_out = s_r.nreq;
  assign node_wr_idx_out = s_r.nidx;
  assign node_wr_data_out = s_r.ndata;
  assign cfg_store_out = s_r.cfg_store;
  assign offline_out = s_r.offline;
  assign busy_out = (s_r.st != GNPCP_ST_IDLE);

  // ========================================================
  // assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  AST_ECHO_CODE: assert property ($rose(s_r.done)
    |-> s_r.rsp[`GNPCP_RSP_CODE] == code)
    else $error("response code not echoed");

  AST_ECHO_TOG: assert property ($rose(s_r.done)
    |-> s_r.rsp[`GNPCP_RSP_TOG] == tog)
    else $error("toggle bit not echoed");

  AST_GET_PERM: assert property (go && code == `GNPCP_CMD_GET_PERM
    |=> s_r.rsp[`GNPCP_RSP_PAY] == {4'h0, $past(sto_sel)})
    else $error("stored parameter not returned");

  AST_RD_PARAM: assert property (go && code == `GNPCP_CMD_RD_PARAM
    |=> s_r.rsp[`GNPCP_RSP_PAY] == {4'h0, $past(img_sel)})
    else $error("parameter image not returned");

  AST_WP_INACTIVE: assert property (go && code == `GNPCP_CMD_WR_PARAM
    && !node_active_in[ridx] |=> !s_r.nreq && s_r.rsp[`GNPCP_RSP_ERR] != `GNPCP_ERR_OK)
    else $error("inactive node addressed");

  AST_WP_ECHO: assert property (s_r.st == GNPCP_ST_WP_WAIT && node_resp_valid_in
    |=> s_r.done && s_r.rsp[`GNPCP_RSP_NIB] == $past(node_resp_data_in))
    else $error("node echo not returned");

  AST_WP_SEND: assert property (go && code == `GNPCP_CMD_WR_PARAM && !s_r.offline
    && node_active_in[ridx] |=> s_r.nreq && s_r.ndata == $past(wparam))
    else $error("written parameter not sent");

  AST_WP_IMAGE: assert property (go && code == `GNPCP_CMD_WR_PARAM && !s_r.offline
    && node_active_in[ridx] |=> img_sel == $past(wparam))
    else $error("parameter image not updated");

  AST_OFFLINE_QUIET: assert property (s_r.offline |-> !s_r.nreq)
    else $error("node traffic while offline");

  AST_CFG_MODE: assert property (go && code == `GNPCP_CMD_STORE_CFG && !cfg_mode_in
    |=> !s_r.cfg_store ##1 !s_r.cfg_store)
    else $error("configuration stored outside configuration mode");

  AST_CFG_PULSE: assert property (go && code == `GNPCP_CMD_STORE_CFG && cfg_mode_in
    |=> s_r.cfg_store)
    else $error("configuration not stored in configuration mode");

  AST_STORE_PRM: assert property (go && code == `GNPCP_CMD_STORE_PRM
    |=> s_r.stored == $past(s_r.image))
    else $error("parameters not copied into stored set");

  AST_OFFLINE_SET: assert property (go && code == `GNPCP_CMD_OFFLINE
    |=> s_r.offline == $past(offl_req))
    else $error("offline flag not taken from request");

  AST_OFFLINE_HOLD: assert property (!(go && code == `GNPCP_CMD_OFFLINE)
    |=> $stable(s_r.offline))
    else $error("offline state changed without command");

  AST_ERR_UNKNOWN: assert property (go && !(code inside {`GNPCP_CMD_GET_PERM,
    `GNPCP_CMD_WR_PARAM, `GNPCP_CMD_RD_PARAM, `GNPCP_CMD_STORE_PRM, `GNPCP_CMD_STORE_CFG,
    `GNPCP_CMD_OFFLINE}) |=> s_r.rsp[`GNPCP_RSP_ERR] == `GNPCP_ERR_UNKNOWN)
    else $error("unknown command not flagged");

  AST_REQ_HOLD: assert property (s_r.st != GNPCP_ST_IDLE |=> $stable(s_r.req))
    else $error("request changed while busy");

  AST_DONE_CLEAR: assert property (apb_wr && paddr_in == `GNPCP_OFS_STAT
    && pwdata_in[`GNPCP_STAT_CLR] && s_r.st == GNPCP_ST_IDLE |=> !s_r.done)
    else $error("done not cleared");

  AST_BOOT_ONLINE: assert property (s_r.st == GNPCP_ST_BOOT |-> !s_r.offline)
    else $error("offline during start");

  AST_BOOT_SEND: assert property (s_r.st == GNPCP_ST_BOOT && node_active_in[s_r.idx]
    |=> s_r.nreq && s_r.ndata == $past(s_r.stored[s_r.idx]))
    else $error("stored parameter not sent at start");

  AST_BOOT_END: assert property (s_r.st == GNPCP_ST_IDLE |-> s_r.idx == `GNPCP_IDX_LAST)
    else $error("start walk ended early");

  COV_WP: cover property (go && code == `GNPCP_CMD_WR_PARAM ##[1:20] $rose(s_r.done));
  COV_WP_REFUSED: cover property (go && code == `GNPCP_CMD_WR_PARAM && !node_active_in[ridx]);
  COV_OFFLINE: cover property ($rose(s_r.offline));
  COV_STORE_CFG: cover property (s_r.cfg_store);
  COV_BOOT_DONE: cover property (s_r.st == GNPCP_ST_BOOT_WAIT ##1 s_r.st == GNPCP_ST_IDLE);

endmodule : gnpcp_top

`default_nettype wire

// >>> verification/gnpcp_node_model.sv
// node side model that answers parameter writes
`timescale 1ns/1ps
`default_nettype none
module gnpcp_node_model (
  // clock
  input wire logic clk_sys_in,
  // request from the block
  input wire logic wr_req_in,
  input wire logic [3:0] wr_data_in,
  // answer timing and echo distortion
  input wire logic [3:0] delay_in,
  input wire logic [3:0] flip_in,
  // answer
  output logic resp_valid_out,
  output logic [3:0] resp_data_out
);
  // ========================================================
  // one request outstanding, answered after delay_in edges
  initial begin
    resp_valid_out = 1'b0;
    resp_data_out = 4'h0;
    forever begin
      @(posedge clk_sys_in);
      if (wr_req_in === 1'b1) begin
        repeat (delay_in) @(posedge clk_sys_in);
        resp_valid_out <= 1'b1;
        resp_data_out <= wr_data_in ^ flip_in;
        @(posedge clk_sys_in);
        resp_valid_out <= 1'b0;
        // line no longer held, so show garbage
        resp_data_out <= ~resp_data_out;
      end
    end
  end
endmodule : gnpcp_node_model
`default_nettype wire

// >>> verification/test_gateway_node_param_cmd_parser.sv
// self-checking bench of the gateway command parser
`timescale 1ns/1ps
`default_nettype none
`include "gnpcp_params.svh"
module test_gateway_node_param_cmd_parser;
  // ========================================================
  // signals
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, cfg = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, perr, rv, wreq, cst, offl, busy;
  logic [3:0] rd, wdat, dly = 4'h1, flip = 4'h0;
  logic [6:0] widx;
  logic [127:0] act = {64'h0, {64{1'b1}}};
  int err_count = 0, total_checks = 0, reqs = 0, cfgs = 0;
  localparam logic [7:0] GP = `GNPCP_CMD_GET_PERM, WP = `GNPCP_CMD_WR_PARAM;
  localparam logic [7:0] RP = `GNPCP_CMD_RD_PARAM, SP = `GNPCP_CMD_STORE_PRM;
  localparam logic [7:0] SC = `GNPCP_CMD_STORE_CFG, OFL = `GNPCP_CMD_OFFLINE;
  localparam logic [6:0] OK = `GNPCP_ERR_OK, EU = `GNPCP_ERR_UNKNOWN;
  localparam logic [6:0] EI = `GNPCP_ERR_INACTIVE, EO = `GNPCP_ERR_OFFLINE;
  localparam logic [6:0] EC = `GNPCP_ERR_NOT_CFG;
  initial forever #20 clk_sys_in = ~clk_sys_in;
  gnpcp_top dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .node_active_in(act), .cfg_mode_in(cfg), .node_resp_valid_in(rv),
    .node_resp_data_in(rd), .node_wr_req_out(wreq), .node_wr_idx_out(widx),
    .node_wr_data_out(wdat), .cfg_store_out(cst), .offline_out(offl),
    .busy_out(busy));
  gnpcp_node_model node_u (.clk_sys_in(clk_sys_in), .wr_req_in(wreq),
    .wr_data_in(wdat), .delay_in(dly), .flip_in(flip), .resp_valid_out(rv),
    .resp_data_out(rd));
  // count node pulses, each is one cycle wide
  always @(posedge clk_sys_in) begin
    if (wreq === 1'b1) reqs++;
    if (cst === 1'b1) cfgs++;
  end
  // ========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // setup then access, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    pen <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `GNPCP_OFS_STAT, 32'h0);
      n++;
    end while (r[b] !== v && n < 400);
    chk({31'h0, r[b]}, {31'h0, v});
  endtask : poll
  // request, start, wait done, read response, clear done
  task automatic cmd(input logic [31:0] q, input logic [23:0] e, input bit full);
    apb(1'b1, `GNPCP_OFS_REQ, q);
    apb(1'b1, `GNPCP_OFS_CTRL, 32'h1);
    poll(0, 1'b1);
    apb(1'b0, `GNPCP_OFS_RSP, 32'h0);
    if (full) chk(r, {8'h00, e});
    else chk({16'h0, r[15:0]}, {16'h0, e[15:0]});
    apb(1'b1, `GNPCP_OFS_STAT, 32'h1);
  endtask : cmd
  // ========================================================
  // watchdog, far beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    test_done();
  end
  // ========================================================
  // scenarios
  initial begin
    repeat (12) @(posedge clk_sys_in);
    chk({31'h0, busy}, 32'h1);
    rstn_in <= 1'b1;
    poll(1, 1'b0);
    chk(reqs, 64);
    chk({28'h0, wdat}, {28'h0, `GNPCP_PARAM_RST});
    chk({31'h0, offl}, 32'h0);
    cmd({24'h000580, GP}, {8'h0F, 1'b1, OK, GP}, 1);
    dly <= 4'h3;
    flip <= 4'h1;
    cmd({24'h060500, WP}, {8'h07, 1'b0, OK, WP}, 1);
    chk({25'h0, widx}, 32'h5);
    chk({28'h0, wdat}, 32'h6);
    cmd({24'h000580, RP}, {8'h06, 1'b1, OK, RP}, 1);
    cmd({24'h000500, GP}, {8'h0F, 1'b0, OK, GP}, 1);
    cmd({24'h092401, WP}, {8'h00, 1'b0, EI, WP}, 0);
    chk(reqs, 65);
    cmd({24'h000080, SP}, {8'h00, 1'b1, OK, SP}, 0);
    cmd({24'h000500, GP}, {8'h06, 1'b0, OK, GP}, 1);
    cmd({24'h000000, SC}, {8'h00, 1'b0, EC, SC}, 0);
    chk(cfgs, 0);
    cfg <= 1'b1;
    cmd({24'h000080, SC}, {8'h00, 1'b1, OK, SC}, 0);
    chk(cfgs, 1);
    cmd({24'h000100, OFL}, {8'h00, 1'b0, OK, OFL}, 0);
    chk({31'h0, offl}, 32'h1);
    cmd({24'h030500, WP}, {8'h00, 1'b0, EO, WP}, 0);
    chk(reqs, 65);
    cmd({24'h000580, GP}, {8'h06, 1'b1, OK, GP}, 1);
    cmd({24'h000000, OFL}, {8'h00, 1'b0, OK, OFL}, 0);
    chk({31'h0, offl}, 32'h0);
    cmd({24'h000000, 8'h55}, {8'h00, 1'b0, EU, 8'h55}, 0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, perr}, 32'h1);
    cmd({24'h000100, OFL}, {8'h00, 1'b0, OK, OFL}, 0);
    // restart while offline
    @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    poll(1, 1'b0);
    chk({31'h0, offl}, 32'h0);
    chk(reqs, 129);
    cmd({24'h000500, RP}, {8'h0F, 1'b0, OK, RP}, 1);
    test_done();
  end
endmodule : test_gateway_node_param_cmd_parser
`default_nettype wire
